// >>> core/disc_drive_if.sv
// Purpose: drive side of the controller interface: index, ready, seek, outer cylinder, flux
// Assumes: controller pins and sensors are asynchronous; power-on is aresetn
// Notes:   registers over AXI4-Lite, one level interrupt
//
// What this block does
// - index pulse once per revolution, nominal period
// - index idles high, falling edge marks track
// - ready low only after supply, speed, recalibration
// - supply faults hold ready high until cleared, recalibrated
// - ready expected within 25 seconds of power-on
// - speed deviation over 2 percent shuts down
// - shutdown lasts until power is cycled
// - seek complete low once heads settled
// - each step pulse moves one track, none past cylinder zero or MAX_CYL
// - direction high outward, low inward
// - outer indication low at cylinder zero
// - flux reversal drives plus above minus
// - control lines accepted only while unit selected
`timescale 1ns/1ns
`include "disc_cfg.svh"
module disc_drive_if
   import disc_pkg::*;
#(
   parameter int          ADDR_W        = 8,
   parameter logic [9:0]  MAX_CYL       = 10'h3FF,
   parameter logic [31:0] REV_CYC       = 32'($rtoi(`REV_PERIOD_MS * 1.0e6 / `CLK_PERIOD_NS + 0.5)),
   parameter logic [31:0] READY_TMO_CYC = 32'(64'(`READY_TMO_S) * 64'd1000000000 / `CLK_PERIOD_NS),
   parameter logic [31:0] RECAL_CYC     = 32'((`RECAL_TIME_US * 1000 + `CLK_PERIOD_NS - 1)
                                              / `CLK_PERIOD_NS)
) (
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // axi4-lite write address and data
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // axi4-lite write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // control lines from the controller
   input  wire logic              unit_select_n,
   input  wire logic              step_n,
   input  wire logic              move_in_n,
   input  wire logic              head_sel_b0_n,
   input  wire logic              head_sel_b1_n,
   input  wire logic              head_sel_b2_n,
   input  wire logic              head_sel_b3_n,
   // status lines to the controller
   output logic                   track_origin_pulse_n,
   output logic                   ready_n,
   output logic                   seek_done_n,
   output logic                   outer_cylinder_n,
   output logic                   read_flux_pos,
   output logic                   read_flux_neg,
   // drive mechanics and sensors
   input  wire logic              supply_ok,
   input  wire logic              spindle_tach,
   input  wire logic              flux_event,
   output logic                   motor_run,
   output logic                   actuator_lock,
   // interrupt
   output logic                   irq
);
   localparam logic [7:0] INDEX_CYC = 8'((`INDEX_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);
   localparam logic [3:0] FLUX_CYC  = 4'((`FLUX_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);

   if (ADDR_W < 4 || ADDR_W > 32 || MAX_CYL == 10'h0 || RECAL_CYC == 32'h0) begin : bad_param
      $error("disc_drive_if parameter out of range");
   end

   typedef struct packed {
      drive_state_type     state;
      logic [9:0]          cyl;
      logic                cyl_known;
      logic [31:0]         act_cnt;
      logic                seek_busy;
      logic [31:0]         wait_cnt;
      logic                was_ready;
      logic [7:0]          idx_cnt;
      logic [3:0]          flux_cnt;
      logic                step_prev;
      logic                flux_prev;
      logic [3:0]          head;
      logic                ready_n;
      logic                seek_done_n;
      logic                origin_n;
      logic                outer_n;
      logic                fpos;
      logic                fneg;
      logic                motor_on;
      logic                act_lock;
      logic                awready;
      logic                wready;
      logic                bvalid;
      logic [1:0]          bresp;
      logic                arready;
      logic                rvalid;
      logic [1:0]          rresp;
      logic [31:0]         rdata;
      logic                aw_have;
      logic                w_have;
      logic [ADDR_W-1:0]   awaddr;
      logic [31:0]         wdata;
      logic [3:0]          wstrb;
      logic [`EV_W-1:0]    int_st;
      logic [`EV_W-1:0]    int_mask;
      logic [15:0]         settle;
      logic                irq;
   } drv_type;

   drv_type            r;
   drv_type            n;
   logic [`PIN_W-1:0]  pins;
   logic [`PIN_W-1:0]  sq;
   logic               rev_pulse;
   logic               at_speed;
   logic [`EV_W-1:0]   ev;
   logic [`EV_W-1:0]   clr;
   logic               sel;
   logic               step_fall;

   // merge a write word into a register through the byte strobes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] strb);
      logic [31:0] m;
      m = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            m[b*8 +: 8] = d[b*8 +: 8];
         end
      end
      return m;
   endfunction

   // ==========================================================
   // pin synchronisers and spindle supervision
   assign pins = {flux_event, spindle_tach, supply_ok, head_sel_b3_n, head_sel_b2_n,
                  head_sel_b1_n, head_sel_b0_n, move_in_n, step_n, unit_select_n};

   pin_sync #(.W(`PIN_W)) u_sync (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .pin_in    (pins),
      .rst_level ({1'b0, {(`PIN_W-1){1'b1}}}),   // flux idles low, all others high
      .level     (sq)
   );

   spindle_monitor #(.REV_CYC(REV_CYC), .TOL_PCT(`SPEED_TOL_PCT)) u_spin (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .tach      (sq[`PIN_TACH]),
      .rev_pulse (rev_pulse),
      .at_speed  (at_speed)
   );

   assign sel       = !sq[`PIN_SEL];
   assign step_fall = r.step_prev && !sq[`PIN_STEP];

   // ==========================================================
   // sequencing, positioning, status lines and register slave
   always_comb begin
      n           = r;
      ev          = '0;
      clr         = '0;
      n.step_prev = sq[`PIN_STEP];
      n.flux_prev = sq[`PIN_FLUX];

      // power-on wait for ready, flagged once when overdue
      if (!r.was_ready && r.wait_cnt != READY_TMO_CYC) begin
         n.wait_cnt = r.wait_cnt + 32'h1;
         if (r.wait_cnt + 32'h1 == READY_TMO_CYC) begin
            ev[`EV_LATE] = 1'b1;
         end
      end

      case (r.state)
         ST_SPINUP: begin
            n.motor_on = 1'b1;
            n.act_lock = 1'b1;
            if (at_speed) begin
               n.state   = ST_RECAL;
               n.act_cnt = RECAL_CYC;
            end
         end
         ST_RECAL: begin
            n.act_lock = 1'b0;
            if (r.act_cnt > 32'h1) begin
               n.act_cnt = r.act_cnt - 32'h1;
            end else begin
               n.state       = ST_READY;
               n.cyl         = 10'h0;
               n.cyl_known   = 1'b1;
               n.ready_n     = 1'b0;
               n.seek_done_n = 1'b0;
               n.was_ready   = 1'b1;
               ev[`EV_READY] = 1'b1;
            end
         end
         ST_READY: begin
            if (sel && step_fall) begin
               if (sq[`PIN_MOVE_IN]) begin
                  if (r.cyl != 10'h0) begin
                     n.cyl = r.cyl - 10'h1;
                  end
               end else if (r.cyl != MAX_CYL) begin
                  n.cyl = r.cyl + 10'h1;
               end
               n.seek_done_n = 1'b1;
               n.seek_busy   = 1'b1;
               n.act_cnt     = {16'h0, r.settle};
            end else if (r.seek_busy) begin
               if (r.act_cnt > 32'h1) begin
                  n.act_cnt = r.act_cnt - 32'h1;
               end else begin
                  n.seek_busy   = 1'b0;
                  n.seek_done_n = 1'b0;
                  ev[`EV_SEEK]  = 1'b1;
               end
            end
            if (sel) begin
               n.head = ~{sq[`PIN_HEAD_LO+3], sq[`PIN_HEAD_LO+2],
                          sq[`PIN_HEAD_LO+1], sq[`PIN_HEAD_LO]};
            end
         end
         ST_SUPPLY: begin
            if (sq[`PIN_SUPPLY]) begin
               n.state = ST_SPINUP;
            end
         end
         ST_SHUTDOWN: begin
            n.motor_on = 1'b0;
            n.act_lock = 1'b1;
         end
         default: begin
            n.state = ST_SHUTDOWN;
         end
      endcase

      // faults override the sequence; a speed loss is final
      if (r.state != ST_SHUTDOWN && r.state != ST_SUPPLY && !sq[`PIN_SUPPLY]) begin
         n.state         = ST_SUPPLY;
         ev[`EV_SUPPLY]  = 1'b1;
      end else if ((r.state == ST_RECAL || r.state == ST_READY) && !at_speed) begin
         n.state         = ST_SHUTDOWN;
         n.motor_on      = 1'b0;
         n.act_lock      = 1'b1;
         ev[`EV_SPEED]   = 1'b1;
      end
      if (n.state != ST_READY) begin
         n.ready_n     = 1'b1;
         n.seek_done_n = 1'b1;
         n.seek_busy   = 1'b0;
      end
      if (n.state == ST_SPINUP || n.state == ST_SUPPLY || n.state == ST_SHUTDOWN) begin
         n.cyl_known = 1'b0;
         n.act_lock  = 1'b1;
      end

      // index pulse from the hall sensor, idle high
      if (rev_pulse && r.motor_on) begin
         n.idx_cnt      = INDEX_CYC;
         ev[`EV_INDEX]  = 1'b1;
      end else if (r.idx_cnt != 8'h0) begin
         n.idx_cnt = r.idx_cnt - 8'h1;
      end
      n.origin_n = (n.idx_cnt == 8'h0);
      n.outer_n  = !(n.cyl_known && n.cyl == 10'h0);

      // flux reversal drives the pair to plus-above-minus
      if (sel && r.state == ST_READY && sq[`PIN_FLUX] && !r.flux_prev) begin
         n.flux_cnt = FLUX_CYC;
      end else if (r.flux_cnt != 4'h0) begin
         n.flux_cnt = r.flux_cnt - 4'h1;
      end
      n.fpos = (n.flux_cnt != 4'h0);
      n.fneg = (n.flux_cnt == 4'h0);

      // axi write channels taken in either order
      if (s_axi_awvalid && r.awready) begin
         n.aw_have = 1'b1;
         n.awaddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && r.wready) begin
         n.w_have = 1'b1;
         n.wdata  = s_axi_wdata;
         n.wstrb  = s_axi_wstrb;
      end
      if (r.bvalid && s_axi_bready) begin
         n.bvalid = 1'b0;
      end
      if (n.aw_have && n.w_have && !n.bvalid) begin
         n.aw_have = 1'b0;
         n.w_have  = 1'b0;
         n.bvalid  = 1'b1;
         n.bresp   = `AXI_RESP_OKAY;
         case ({n.awaddr[ADDR_W-1:2], 2'b00})
            ADDR_W'(`REG_STATUS): ;                   // read only, write ignored
            ADDR_W'(`REG_INT_STATUS): begin
               clr = `EV_W'(merge(32'h0, n.wdata, n.wstrb));
            end
            ADDR_W'(`REG_INT_MASK): begin
               n.int_mask = `EV_W'(merge({26'h0, r.int_mask}, n.wdata, n.wstrb));
            end
            ADDR_W'(`REG_SETTLE): begin
               n.settle = 16'(merge({16'h0, r.settle}, n.wdata, n.wstrb));
            end
            default: begin
               n.bresp = `AXI_RESP_SLVERR;
            end
         endcase
      end
      n.awready = !n.aw_have && !n.bvalid;
      n.wready  = !n.w_have && !n.bvalid;

      // axi read
      if (r.rvalid && s_axi_rready) begin
         n.rvalid = 1'b0;
      end
      if (s_axi_arvalid && r.arready) begin
         n.rvalid = 1'b1;
         n.rresp  = `AXI_RESP_OKAY;
         n.rdata  = 32'h0;
         case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
            ADDR_W'(`REG_STATUS): begin
               n.rdata[`STAT_STATE_LO +: 3] = r.state;
               n.rdata[`STAT_READY]         = !r.ready_n;
               n.rdata[`STAT_AT_SPEED]      = at_speed;
               n.rdata[`STAT_HEAD_LO +: 4]  = r.head;
               n.rdata[`STAT_CYL_LO +: 10]  = r.cyl;
            end
            ADDR_W'(`REG_INT_STATUS): n.rdata[`EV_W-1:0] = r.int_st;
            ADDR_W'(`REG_INT_MASK):   n.rdata[`EV_W-1:0] = r.int_mask;
            ADDR_W'(`REG_SETTLE):     n.rdata[15:0]      = r.settle;
            default: begin
               n.rresp = `AXI_RESP_SLVERR;
            end
         endcase
      end
      n.arready = !n.rvalid;

      // sticky events, a new event wins over a clear
      n.int_st = (r.int_st & ~clr) | ev;
      n.irq    = |(n.int_st & n.int_mask);
   end

   // state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r             <= '0;
         r.state       <= ST_SPINUP;
         r.ready_n     <= 1'b1;
         r.seek_done_n <= 1'b1;
         r.origin_n    <= 1'b1;
         r.outer_n     <= 1'b1;
         r.fneg        <= 1'b1;
         r.motor_on    <= 1'b1;
         r.act_lock    <= 1'b1;
         r.step_prev   <= 1'b1;
         r.settle      <= `SETTLE_RST;
      end else begin
         r <= n;
      end
   end

   // ==========================================================
   // outputs straight from the state register
   assign s_axi_awready        = r.awready;
   assign s_axi_wready         = r.wready;
   assign s_axi_bvalid         = r.bvalid;
   assign s_axi_bresp          = r.bresp;
   assign s_axi_arready        = r.arready;
   assign s_axi_rvalid         = r.rvalid;
   assign s_axi_rresp          = r.rresp;
   assign s_axi_rdata          = r.rdata;
   assign track_origin_pulse_n = r.origin_n;
   assign ready_n              = r.ready_n;
   assign seek_done_n          = r.seek_done_n;
   assign outer_cylinder_n     = r.outer_n;
   assign read_flux_pos        = r.fpos;
   assign read_flux_neg        = r.fneg;
   assign motor_run            = r.motor_on;
   assign actuator_lock        = r.act_lock;
   assign irq                  = r.irq;
endmodule

// >>> core/pin_sync.sv
// Purpose: three-stage synchroniser for asynchronous pins
// Assumes: inputs come from outside the aclk domain
// Notes:   output follows once the second and third stages agree
`timescale 1ns/1ns
module pin_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // pins in, filtered levels out
   input  wire logic [W-1:0] pin_in,
   input  wire logic [W-1:0] rst_level,
   output logic      [W-1:0] level
);
   if (W < 1) begin : bad_width
      $error("pin_sync needs at least one bit");
   end

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } sync_type;

   sync_type     r;
   sync_type     n;
   logic [W-1:0] agree;

   // per bit: a change counts once stages two and three agree
   for (genvar i = 0; i < W; i++) begin : g_bit
      assign agree[i] = (r.s2[i] == r.s3[i]) ? r.s3[i] : r.q[i];
   end

   // next stage values
   always_comb begin
      n    = r;
      n.s1 = pin_in;
      n.s2 = r.s1;
      n.s3 = r.s2;
      n.q  = agree;
   end

   // state register; reset levels are the idle pin levels
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= {rst_level, rst_level, rst_level, rst_level};
      end else begin
         r <= n;
      end
   end

   assign level = r.q;
endmodule

// >>> core/spindle_monitor.sv
// Purpose: measures the revolution period from the hall sensor
// Assumes: tach is a synchronised level, one falling edge per revolution
// Notes:   missing edges also drop at_speed once the upper bound passes
`timescale 1ns/1ns
module spindle_monitor #(
   parameter logic [31:0] REV_CYC = 32'd1667000,
   parameter int          TOL_PCT = 2
) (
   // clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // sensor and results
   input  wire logic tach,
   output logic      rev_pulse,
   output logic      at_speed
);
   localparam logic [31:0] TOL_CYC = 32'(REV_CYC * TOL_PCT / 100);
   localparam logic [31:0] LO_CYC  = REV_CYC - TOL_CYC;
   localparam logic [31:0] HI_CYC  = REV_CYC + TOL_CYC;

   if (REV_CYC < 32'd16 || TOL_PCT < 0 || TOL_PCT > 50) begin : bad_param
      $error("spindle_monitor period or tolerance out of range");
   end

   typedef struct packed {
      logic [31:0] cnt;
      logic        tach_prev;
      logic        rev_pulse;
      logic        at_speed;
   } mon_type;

   mon_type r;
   mon_type n;

   // period measurement, deviation beyond tolerance drops at_speed
   always_comb begin
      n           = r;
      n.tach_prev = tach;
      n.rev_pulse = 1'b0;
      if (r.tach_prev && !tach) begin
         n.rev_pulse = 1'b1;
         n.at_speed  = ((r.cnt + 32'h1) >= LO_CYC) && ((r.cnt + 32'h1) <= HI_CYC);
         n.cnt       = 32'h0;
      end else begin
         if (r.cnt != 32'hFFFFFFFF) begin
            n.cnt = r.cnt + 32'h1;
         end
         if (r.cnt > HI_CYC) begin
            n.at_speed = 1'b0;
         end
      end
   end

   // state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= '{tach_prev: 1'b1, default: '0};
      end else begin
         r <= n;
      end
   end

   assign rev_pulse = r.rev_pulse;
   assign at_speed  = r.at_speed;
endmodule

// >>> pkg/disc_cfg.svh
// Purpose: offsets, field positions, reset values and timing figures of the drive interface
// Assumes: 100 MHz aclk
// Notes:   definitions only
`ifndef DISC_CFG_SVH
`define DISC_CFG_SVH

// ==========================================================
// clock and timing figures, each in its own unit
`define CLK_PERIOD_NS   10
`define REV_PERIOD_MS   16.67
`define SPEED_TOL_PCT   2
`define READY_TMO_S     25
`define RECAL_TIME_US   100
`define INDEX_TIME_NS   1000
`define FLUX_TIME_NS    40

// ==========================================================
// register byte offsets
`define REG_STATUS      8'h00
`define REG_INT_STATUS  8'h04
`define REG_INT_MASK    8'h08
`define REG_SETTLE      8'h0C
`define SETTLE_RST      16'h1388

// ==========================================================
// axi responses
`define AXI_RESP_OKAY   2'h0
`define AXI_RESP_SLVERR 2'h2

// ==========================================================
// event bits of status and mask registers
`define EV_READY        0
`define EV_SEEK         1
`define EV_SPEED        2
`define EV_SUPPLY       3
`define EV_LATE         4
`define EV_INDEX        5
`define EV_W            6

// ==========================================================
// fields of the drive status register
`define STAT_STATE_LO   0
`define STAT_READY      3
`define STAT_AT_SPEED   4
`define STAT_HEAD_LO    5
`define STAT_CYL_LO     16

// ==========================================================
// positions of the pins in the synchroniser vector
`define PIN_SEL         0
`define PIN_STEP        1
`define PIN_MOVE_IN     2
`define PIN_HEAD_LO     3
`define PIN_SUPPLY      7
`define PIN_TACH        8
`define PIN_FLUX        9
`define PIN_W           10

`endif

// >>> pkg/disc_pkg.sv
// Purpose: shared types of the drive interface
// Assumes: nothing
// Notes:   state codes are read back through the status register
package disc_pkg;

   // ==========================================================
   // drive sequencing states
   typedef enum logic [2:0] {
      ST_SPINUP   = 3'h0,
      ST_RECAL    = 3'h1,
      ST_READY    = 3'h2,
      ST_SUPPLY   = 3'h3,
      ST_SHUTDOWN = 3'h4
   } drive_state_type;

endpackage

// >>> verif/ctrl_model.sv
// Purpose: controller model that positions the heads by step pulses
// Assumes: seek complete arrives asynchronously
// Notes:   seek is called from the testbench
`timescale 1ns/1ns
module ctrl_model (
   // clock and status in
   input  wire logic aclk,
   input  wire logic seek_done_n,
   // control lines out
   output logic       unit_select_n,
   output logic       step_n,
   output logic       move_in_n,
   output logic [3:0] head_n
);
   logic [1:0] done_s;
   int         t;
   // two-stage synchroniser on seek complete
   always @(posedge aclk) done_s <= {done_s[0], seek_done_n};
   // idle: deselected, all head lines inactive
   initial begin
      unit_select_n = 1'b1;
      step_n = 1'b1;
      move_in_n = 1'b1;
      head_n = 4'hF;
   end
   // select, direction and head first, then one pulse per track
   task automatic seek(input logic inw, input int k, input logic sel, input logic [3:0] hd);
      @(posedge aclk);
      unit_select_n <= !sel;
      move_in_n <= !inw;
      head_n <= ~hd;
      repeat (6) @(posedge aclk);
      repeat (k) begin
         step_n <= 1'b0;
         repeat (6) @(posedge aclk);
         step_n <= 1'b1;
         repeat (4) @(posedge aclk);
         t = 0;
         while (done_s[1] && t++ < 500) @(posedge aclk);
      end
   endtask
endmodule

// >>> verif/disc_drive_checker.sv
// Purpose: port-level checks of the drive interface
// Assumes: sees only ports of disc_drive_if
// Notes:   bound at the foot of this file
`timescale 1ns/1ns
module disc_drive_checker (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // control lines in
   input wire logic unit_select_n,
   input wire logic step_n,
   input wire logic move_in_n,
   input wire logic supply_ok,
   // status and mechanics out
   input wire logic track_origin_pulse_n,
   input wire logic ready_n,
   input wire logic seek_done_n,
   input wire logic outer_cylinder_n,
   input wire logic read_flux_pos,
   input wire logic read_flux_neg,
   input wire logic motor_run,
   input wire logic actuator_lock
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ==========================================================
   // ready, spindle and shutdown
   a_ready_motor: assert property (!ready_n |-> motor_run && !actuator_lock)
      else $error("ready while spindle off or locked");
   a_stop_sticks: assert property (!motor_run |=> !motor_run && ready_n)
      else $error("spindle restarted after shutdown");
   a_supply_drop: assert property ($fell(supply_ok) |-> ##[3:7] ready_n)
      else $error("ready kept on supply fault");
   a_ready_outer: assert property ($fell(ready_n) |-> ##[0:1] !outer_cylinder_n)
      else $error("ready without outer cylinder");
   // ==========================================================
   // seek, index and flux
   a_step_busy: assert property ($fell(step_n) && !unit_select_n && !ready_n
      && (outer_cylinder_n || !move_in_n) |-> ##[3:8] seek_done_n)
      else $error("step did not raise seek busy");
   a_index_low: assert property ($fell(track_origin_pulse_n) |-> !track_origin_pulse_n [*8])
      else $error("index pulse too short");
   a_flux_pair: assert property (read_flux_pos == !read_flux_neg)
      else $error("flux lines not complementary");
   a_flux_width: assert property ($rose(read_flux_pos) |-> read_flux_pos [*4] ##1 !read_flux_pos)
      else $error("flux pulse width wrong");
endmodule

bind disc_drive_if disc_drive_checker u_chk (.*);

// >>> verif/testbench.sv
// Purpose: self-checking bench of the drive interface
// Assumes: short revolution, recal and timeout counts
// Notes:   random head and step counts from a fixed seed
`timescale 1ns/1ns
`include "disc_cfg.svh"
module testbench import disc_pkg::*; ;
   localparam int REV = 200;
   logic aclk = 0, aresetn = 0, supply_ok = 1, spindle_tach = 1, flux_event = 0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hF, head_n, head;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, unit_select_n, step_n, move_in_n, track_origin_pulse_n, ready_n;
   logic seek_done_n, outer_cylinder_n, read_flux_pos, read_flux_neg, motor_run;
   logic actuator_lock, irq;
   int fail_count = 0, checked = 0, per = REV, tc = 0, cyl = 0, k, t;
   time tm;
   disc_drive_if #(.REV_CYC(32'(REV)), .READY_TMO_CYC(32'h000007D0),
      .RECAL_CYC(32'h00000014)) uut (.*, .head_sel_b0_n(head_n[0]),
      .head_sel_b1_n(head_n[1]), .head_sel_b2_n(head_n[2]), .head_sel_b3_n(head_n[3]));
   ctrl_model ctrl (.*);
   // clock and spindle sensor, one falling edge each revolution
   always #5 aclk = ~aclk;
   always @(posedge aclk) begin
      tc <= (tc + 1 >= per) ? 0 : tc + 1;
      spindle_tach <= tc < per / 2;
   end
   // ==========================================================
   // compare, bus cycles, waits and expectations
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %0t got %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, {a[4], 1'b0});
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      d[31] = d[31] | (s_axi_rresp != `AXI_RESP_OKAY);
      s_axi_rready <= 1'b0;
   endtask
   task automatic wt(ref logic s, input logic v, input int lim);
      t = 0;
      while (s !== v && t++ < lim) @(posedge aclk);
      chk(s, v);
   endtask
   function automatic int next_cyl(input int c, input bit inw, input int n);
      return inw ? ((c + n > 1023) ? 1023 : c + n) : ((c < n) ? 0 : c - n);
   endfunction
   task automatic results;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // watchdog
   initial begin
      #400000;
      fail_count++;
      results;
   end
   // ==========================================================
   // main sequence
   initial begin
      void'($urandom(85579));
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`REG_SETTLE);
      chk(d, {16'h0000, `SETTLE_RST});
      rd(8'h10);
      chk(d[31], 1'b1);
      wr(8'h10, 32'h1);
      $display("reset test done");
      wt(ready_n, 1'b0, 3000);
      chk(outer_cylinder_n, 1'b0);
      rd(`REG_INT_STATUS);
      chk(d[`EV_LATE], 1'b0);
      @(negedge track_origin_pulse_n);
      tm = $time;
      @(negedge track_origin_pulse_n);
      chk(32'(($time - tm) / 10), REV);
      $display("ready test done");
      wr(`REG_SETTLE, 32'h8);
      wr(`REG_INT_MASK, 32'h1 << `EV_SEEK);
      head = 4'($urandom);
      // inward random, outward past cylinder 0, then deselected
      for (int i = 0; i < 3; i++) begin
         k = (i == 0) ? 1 + $urandom % 6 : (i == 1) ? cyl + 2 : 3;
         ctrl.seek(i != 1, k, i != 2, head);
         if (i != 2) cyl = next_cyl(cyl, i != 1, k);
         rd(`REG_STATUS);
         chk(d[25:16], cyl);
         chk(outer_cylinder_n, cyl != 0);
      end
      chk(d[8:5], head);
      chk(irq, 1'b1);
      wr(`REG_INT_STATUS, 32'h3F);
      repeat (REV + 10) @(posedge aclk);
      rd(`REG_INT_STATUS);
      chk({d[`EV_INDEX], irq}, 2'b10);
      $display("seek test done");
      for (int s = 0; s < 2; s++) begin
         ctrl.seek(1'b1, 0, s[0], head);
         flux_event <= 1'b1;
         t = 0;
         repeat (10) @(posedge aclk) t = t | read_flux_pos;
         chk(t, s);
         flux_event <= 1'b0;
      end
      supply_ok <= 1'b0;
      wt(ready_n, 1'b1, 20);
      supply_ok <= 1'b1;
      wt(ready_n, 1'b0, 3000);
      per <= 230;
      wt(motor_run, 1'b0, 2000);
      chk({ready_n, actuator_lock}, 2'b11);
      per <= REV;
      ctrl.seek(1'b1, 2, 1'b1, head);
      rd(`REG_STATUS);
      chk({d[2:0], motor_run, ready_n}, {ST_SHUTDOWN, 2'b01});
      $display("fault test done");
      results;
   end
endmodule
